// [hdl/flash_bus_cycle.sv]
// Purpose: one asynchronous flash bus cycle, write or read, from pclk
// Assumes: a request comes only while the previous cycle has finished
// Notes: address is set before the write strobe falls, data before it rises; a read drops oe with the address
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_bus_cycle (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input wire flash_host_pkg::cyc_req_type req,
	input wire logic [7:0] dq_in,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [18:0] addr,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic done,
	output logic [7:0] rdata
);

	localparam logic [3:0] WP_CYC = 4'(`WP_CYC);
	localparam logic [3:0] ACC_CYC = 4'(`ACC_CYC);
	localparam logic [3:0] REC_CYC = 4'(`REC_CYC);

	typedef struct packed {
		flash_host_pkg::cyc_state_type st;
		logic [3:0] cnt;
		logic is_write;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic dq_oe;
		logic [18:0] addr;
		logic [7:0] dq_out;
		logic [7:0] rdata;
		logic done;
	} cyc_regs_type;

	localparam cyc_regs_type RESET_REGS = '{st: flash_host_pkg::CYC_IDLE, cnt: 4'h0,
		is_write: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0,
		addr: 19'h0_0000, dq_out: 8'h00, rdata: 8'h00, done: 1'b0};

	cyc_regs_type r;
	cyc_regs_type next_r;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		unique case (r.st)
			flash_host_pkg::CYC_IDLE: begin
				if (req_valid) begin
					next_r.addr = req.addr;
					next_r.dq_out = req.data;
					next_r.is_write = req.write;
					next_r.dq_oe = req.write;
					next_r.ce_n = 1'b0;
					// a read drops output enable at once; each read is its own oe pulse [R8]
					next_r.oe_n = req.write;
					next_r.cnt = ACC_CYC - 4'h1;
					next_r.st = req.write ? flash_host_pkg::CYC_SETUP : flash_host_pkg::CYC_STROBE;
				end
			end
			flash_host_pkg::CYC_SETUP: begin
				// address already stable when write enable falls [R15]
				next_r.we_n = 1'b0;
				next_r.cnt = WP_CYC - 4'h1;
				next_r.st = flash_host_pkg::CYC_STROBE;
			end
			flash_host_pkg::CYC_STROBE: begin
				if (r.cnt == 4'h0) begin
					// data held over the rising edge, released only after recovery [R15]
					next_r.we_n = 1'b1;
					next_r.oe_n = 1'b1;
					next_r.ce_n = 1'b1;
					if (!r.is_write) begin
						next_r.rdata = dq_in;
					end
					next_r.cnt = REC_CYC - 4'h1;
					next_r.st = flash_host_pkg::CYC_HOLD;
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
			flash_host_pkg::CYC_HOLD: begin
				if (r.cnt == 4'h0) begin
					next_r.dq_oe = 1'b0;
					next_r.done = 1'b1;
					next_r.st = flash_host_pkg::CYC_IDLE;
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= RESET_REGS;
		end else begin
			r <= next_r;
		end
	end

	assign ce_n = r.ce_n;
	assign we_n = r.we_n;
	assign oe_n = r.oe_n;
	assign addr = r.addr;
	assign dq_out = r.dq_out;
	assign dq_oe = r.dq_oe;
	assign done = r.done;
	assign rdata = r.rdata;

endmodule

// [hdl/flash_host_cfg.svh]
// Purpose: constants of the flash command/status host controller
// Assumes: 10 MHz pclk, byte-wide asynchronous flash with 19 address lines
// Notes: offsets are byte addresses on the APB register window
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CTRL_OFS 12'h000
`define ADDR_OFS 12'h004
`define WDATA_OFS 12'h008
`define STATUS_OFS 12'h00C
`define RDATA_OFS 12'h010

// ----------------------------------------
// flash command words
// ----------------------------------------
`define UNLOCK1_ADDR 19'h0_5555
`define UNLOCK1_DATA 8'hAA
`define UNLOCK2_ADDR 19'h0_2AAA
`define UNLOCK2_DATA 8'h55
`define CMD_ADDR 19'h0_5555
`define RESET_ADDR 19'h0_2555
`define RESET_CMD 8'hF0
`define PROG_CMD 8'hA0
`define IDENT_CMD 8'h90
`define ERASE_SETUP_CMD 8'h80
`define ERASE_CONFIRM_CMD 8'h10

// ----------------------------------------
// status byte fields
// ----------------------------------------
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define FAIL_BIT 5
`define TIMER_BIT 3
`define STATUS_MASK 8'hE8

// ----------------------------------------
// pin timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define T_WP_NS 50
`define T_ACC_NS 150
`define T_WPH_NS 20
`define T_DF_NS 35
`define WP_CYC ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYC ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_NS ((`T_WPH_NS > `T_DF_NS) ? `T_WPH_NS : `T_DF_NS)
`define REC_CYC ((`REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [hdl/flash_host_ctrl.sv]
// Purpose: APB-controlled host that drives flash instructions and polls status
// Assumes: one operation at a time; software waits for done before the next
// Notes: APB slave answers with zero wait states
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

// Notes on behaviour
// R1 - during a program the poll bit reads inverted written data.
// R2 - during an erase the poll bit reads zero.
// R3 - after completion the poll bit shows true data, or one after erase.
// R4 - poll and toggle status valid only after last write of the sequence.
// R5 - host polls at the programmed address or inside the erased sector.
// R6 - protected target shows inverted poll bit briefly, then array data.
// R7 - programming a protected byte leaves it unchanged.
// R8 - toggle bit inverts on every separate read while busy.
// R9 - two equal toggle reads mean done; next read yields the data.
// R10 - protected target toggles briefly, then returns to read mode.
// R11 - failed program or erase sets the failure flag bit.
// R12 - the read/reset instruction clears the failure flag bit.
// R13 - erase wait timer bit is zero while erase start is pending.
// R14 - unlock is AAh at 5555h then 55h at 2AAAh.
// R15 - address taken at strobe fall, data at strobe rise.
// R16 - unlock writes are cycles one, two, and four, five for confirms.
// R17 - read/reset is F0h at 2555h; afterwards reads return array bytes.
// R18 - identity read is unlock plus 90h at 5555h, then coded reads.
// R19 - identity mode with address bit one high reads sector protection.
// R20 - whole erase is unlock, 80h, unlock, 10h at 5555h.
// R21 - bad confirm or bad unlock aborts to array read.
// R22 - controller preprograms to zero, erase leaves every byte at FFh.
// R23 - after the sixth erase write, reads return status bits.
// R24 - any invalid command order returns the device to array read.
// R25 - host masks status bits zero, one, two and four.
// R26 - program is unlock, A0h, then address and data write.
// R27 - the device powers up in array read mode.
// R28 - host starts no new program or erase until current one completes.
module flash_host_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic [18:0] flash_addr,
	input wire logic [7:0] flash_dq_in,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe
);

	typedef struct packed {
		flash_host_pkg::main_state_type st;
		flash_host_pkg::op_type op;
		logic [2:0] step;
		logic wait_eng;
		logic req_valid;
		flash_host_pkg::cyc_req_type req;
		logic [18:0] addr;
		logic [7:0] wdata;
		logic busy;
		logic done;
		logic err;
		logic [7:0] prev;
		logic [7:0] status;
		logic [7:0] rdata;
		logic [31:0] prdata;
		logic pslverr;
	} main_regs_type;

	main_regs_type r;
	main_regs_type next_r;
	logic eng_done;
	logic [7:0] eng_rdata;

	// ----------------------------------------
	// instruction sequences
	// ----------------------------------------
	function automatic flash_host_pkg::cyc_req_type seq_step(input flash_host_pkg::op_type op,
		input logic [2:0] idx, input logic [18:0] a, input logic [7:0] d);
		flash_host_pkg::cyc_req_type s;
		s = '{write: 1'b1, addr: `UNLOCK1_ADDR, data: `UNLOCK1_DATA};
		if (op == flash_host_pkg::OP_RESET) begin
			s = '{write: 1'b1, addr: `RESET_ADDR, data: `RESET_CMD}; // [R17]
		end else if (op == flash_host_pkg::OP_READ) begin
			s = '{write: 1'b0, addr: a, data: 8'h00};
		end else begin
			unique case (idx)
				3'h0, 3'h3: s = '{write: 1'b1, addr: `UNLOCK1_ADDR, data: `UNLOCK1_DATA}; // [R14] [R16]
				3'h1, 3'h4: s = '{write: 1'b1, addr: `UNLOCK2_ADDR, data: `UNLOCK2_DATA}; // [R14] [R16]
				3'h2: begin
					if (op == flash_host_pkg::OP_PROGRAM) begin
						s = '{write: 1'b1, addr: `CMD_ADDR, data: `PROG_CMD}; // [R26]
					end else if (op == flash_host_pkg::OP_IDENT) begin
						s = '{write: 1'b1, addr: `CMD_ADDR, data: `IDENT_CMD}; // [R18]
					end else begin
						s = '{write: 1'b1, addr: `CMD_ADDR, data: `ERASE_SETUP_CMD}; // [R20]
					end
				end
				3'h5: s = '{write: 1'b1, addr: `CMD_ADDR, data: `ERASE_CONFIRM_CMD}; // [R20]
				default: begin
					// program writes target byte; identity reads the coded address [R26] [R18] [R19]
					s = '{write: (op == flash_host_pkg::OP_PROGRAM), addr: a, data: d};
				end
			endcase
			if (op == flash_host_pkg::OP_PROGRAM && idx == 3'h3) begin
				s = '{write: 1'b1, addr: a, data: d}; // [R26]
			end else if (op == flash_host_pkg::OP_IDENT && idx == 3'h3) begin
				s = '{write: 1'b0, addr: a, data: 8'h00};
			end
		end
		return s;
	endfunction

	function automatic logic [2:0] seq_last(input flash_host_pkg::op_type op);
		logic [2:0] n;
		n = 3'h0;
		if (op == flash_host_pkg::OP_PROGRAM || op == flash_host_pkg::OP_IDENT) begin
			n = 3'h3;
		end else if (op == flash_host_pkg::OP_ERASE) begin
			n = 3'h5;
		end
		return n;
	endfunction

	// ----------------------------------------
	// register file and sequencer
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.req_valid = 1'b0;
		if (psel && !penable) begin
			next_r.pslverr = 1'b0;
			next_r.prdata = 32'h0000_0000;
			unique case (paddr)
				`CTRL_OFS: next_r.prdata = {29'h0000_0000, r.op};
				`ADDR_OFS: next_r.prdata = {13'h0000, r.addr};
				`WDATA_OFS: next_r.prdata = {24'h00_0000, r.wdata};
				`STATUS_OFS: next_r.prdata = {16'h0000, r.status, 5'h00, r.err, r.done, r.busy};
				`RDATA_OFS: next_r.prdata = {24'h00_0000, r.rdata};
				default: next_r.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && pwrite) begin
			if (paddr == `ADDR_OFS) begin
				next_r.addr = pwdata[18:0];
			end else if (paddr == `WDATA_OFS) begin
				next_r.wdata = pwdata[7:0];
			end else if (paddr == `CTRL_OFS && !r.busy) begin
				// starts are ignored while an operation runs [R28]
				next_r.done = 1'b0;
				next_r.err = 1'b0;
				next_r.status = 8'h00;
				if (pwdata[2:0] > 3'h4) begin
					next_r.err = 1'b1;
					next_r.done = 1'b1;
				end else begin
					next_r.op = flash_host_pkg::op_type'(pwdata[2:0]);
					next_r.step = 3'h0;
					next_r.busy = 1'b1;
					next_r.wait_eng = 1'b0;
					next_r.st = flash_host_pkg::M_SEQ;
				end
			end
		end
		if (r.st != flash_host_pkg::M_IDLE && !r.wait_eng) begin
			next_r.wait_eng = 1'b1;
			next_r.req_valid = 1'b1;
			if (r.st == flash_host_pkg::M_SEQ) begin
				next_r.req = seq_step(r.op, r.step, r.addr, r.wdata);
			end else begin
				// polling stays on the target address [R5]
				next_r.req = '{write: 1'b0, addr: r.addr, data: 8'h00};
			end
		end else if (eng_done) begin
			next_r.wait_eng = 1'b0;
			unique case (r.st)
				flash_host_pkg::M_SEQ: begin
					if (r.step == seq_last(r.op)) begin
						next_r.step = 3'h0;
						if (r.op == flash_host_pkg::OP_PROGRAM || r.op == flash_host_pkg::OP_ERASE) begin
							// status only read once the whole sequence is written [R4] [R23]
							next_r.st = flash_host_pkg::M_POLL_A;
						end else begin
							if (r.op != flash_host_pkg::OP_RESET) begin
								next_r.rdata = eng_rdata;
							end
							next_r.busy = 1'b0;
							next_r.done = 1'b1;
							next_r.st = flash_host_pkg::M_IDLE;
						end
					end else begin
						next_r.step = r.step + 3'h1;
					end
				end
				flash_host_pkg::M_POLL_A: begin
					next_r.prev = eng_rdata;
					next_r.st = flash_host_pkg::M_POLL_B;
				end
				flash_host_pkg::M_POLL_B, flash_host_pkg::M_POLL_C: begin
					next_r.status = eng_rdata & `STATUS_MASK; // [R25]
					next_r.prev = eng_rdata;
					if (eng_rdata[`TOGGLE_BIT] == r.prev[`TOGGLE_BIT]) begin
						next_r.st = flash_host_pkg::M_FINAL; // [R9]
					end else if (r.st == flash_host_pkg::M_POLL_C) begin
						// still toggling after failure flag: clear it with read/reset [R11] [R12]
						next_r.err = 1'b1;
						next_r.op = flash_host_pkg::OP_RESET;
						next_r.step = 3'h0;
						next_r.st = flash_host_pkg::M_SEQ;
					end else if (eng_rdata[`FAIL_BIT]) begin
						next_r.st = flash_host_pkg::M_POLL_C; // [R11]
					end
				end
				flash_host_pkg::M_FINAL: begin
					// read after toggling stops gives the settled byte [R9] [R3]
					next_r.rdata = eng_rdata;
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
					next_r.st = flash_host_pkg::M_IDLE;
				end
				default: next_r.st = flash_host_pkg::M_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{st: flash_host_pkg::M_IDLE, op: flash_host_pkg::OP_RESET,
				req: '{write: 1'b0, addr: 19'h0_0000, data: 8'h00}, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// pin engine
	// ----------------------------------------
	flash_bus_cycle cycle_engine (
		.pclk(pclk),
		.presetn(presetn),
		.req_valid(r.req_valid),
		.req(r.req),
		.dq_in(flash_dq_in),
		.ce_n(flash_ce_n),
		.we_n(flash_we_n),
		.oe_n(flash_oe_n),
		.addr(flash_addr),
		.dq_out(flash_dq_out),
		.dq_oe(flash_dq_oe),
		.done(eng_done),
		.rdata(eng_rdata)
	);

	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = r.pslverr;

endmodule

// [hdl/flash_host_pkg.sv]
// Purpose: types shared by the flash host controller files
// Assumes: nothing beyond the cfg header
// Notes: none
package flash_host_pkg;

	typedef enum logic [2:0] {
		OP_RESET = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_ERASE = 3'h2,
		OP_IDENT = 3'h3,
		OP_READ = 3'h4
	} op_type;

	typedef enum logic [1:0] {
		CYC_IDLE = 2'h0,
		CYC_SETUP = 2'h1,
		CYC_STROBE = 2'h3,
		CYC_HOLD = 2'h2
	} cyc_state_type;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_SEQ = 3'h1,
		M_POLL_A = 3'h3,
		M_POLL_B = 3'h2,
		M_POLL_C = 3'h6,
		M_FINAL = 3'h7
	} main_state_type;

	typedef struct packed {
		logic write;
		logic [18:0] addr;
		logic [7:0] data;
	} cyc_req_type;

endpackage

// [tb/flash_device_model.sv]
// Purpose: behavioural byte-wide flash with command decode and status bits
// Assumes: busy time is counted in status reads, not in time
// Notes: one sector is protected; a failure keeps it busy until reset
`timescale 1ns/1ps
module flash_device_model #(
	parameter logic [7:0] maker_code = 8'h5A,
	parameter logic [7:0] part_code = 8'hC3,
	parameter logic [2:0] guarded = 3'h7
) (
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [18:0] addr,
	input wire logic [7:0] din,
	input wire logic fail_set,
	output logic [7:0] dq
);
	// ----
	// command and status state
	// ----
	logic [7:0] mem [logic [18:0]];
	logic [26:0] k;
	logic [18:0] la;
	logic [7:0] q, pv;
	logic [2:0] step;
	logic ident, busy, fl, tog, tmr;
	int left;
	wire logic wstb = ce_n | we_n;
	// released bus shows the inverse, never a stale copy
	assign dq = (!ce_n && !oe_n) ? q : ~q;
	initial begin
		{step, ident, busy, fl, tog} = '0;
		tmr = 1'b1;
		q = 8'h00;
	end
	task automatic run(input logic e, input logic [18:0] a, input logic [7:0] d);
		logic p;
		p = !e && a[18:16] == guarded;
		pv = e ? 8'hFF : d;
		busy = 1'b1;
		tmr = !e;
		fl = fail_set;
		left = p ? 2 : 4;
		if (e) begin
			mem.delete();
		end else if (!p) begin
			mem[a] = d;
		end
	endtask
	always @(negedge wstb) begin
		la = addr;
	end
	// strobes seen before the host leaves reset carry unknowns; exact compares keep them out
	always @(posedge wstb) begin
		k = {la, din};
		if (k === 27'h25_55F0) begin
			{step, ident, busy, fl} = '0;
		end else if (!busy) begin
			case (step)
			3'h0, 3'h3: step = (k === 27'h55_55AA) ? step + 3'h1 : 3'h0;
			3'h1, 3'h4: step = (k === 27'h2A_AA55) ? step + 3'h1 : 3'h0;
			3'h2: begin
				ident = ident | (k === 27'h55_5590);
				step = (k === 27'h55_55A0) ? 3'h6 : (k === 27'h55_5580) ? 3'h3 : 3'h0;
			end
			3'h5: begin
				step = 3'h0;
				if (k === 27'h55_5510) begin
					run(1'b1, la, din);
				end
			end
			default: begin
				step = 3'h0;
				run(1'b0, la, din);
			end
			endcase
		end
	end
	always @(negedge oe_n or negedge ce_n) begin
		// address moves in the same step as the enables; let it settle first
		#1;
		if (!oe_n && !ce_n) begin
			if (busy) begin
				tog = ~tog;
				q = {~pv[7], tog, fl, 1'b1, tmr, 3'h5};
				tmr = 1'b1;
				left = fl ? left : left - 1;
				busy = left > 0;
			end else if (ident) begin
				q = addr[1] ? {7'h00, addr[18:16] == guarded} : addr[0] ? part_code : maker_code;
			end else begin
				q = mem.exists(addr) ? mem[addr] : 8'hFF;
			end
		end
	end
endmodule

// [tb/flash_host_ctrl_test.sv]
// Purpose: self-checking bench for the flash host controller
// Assumes: model busy time is a few status reads
// Notes: each read notes its expectation in a queue; a monitor compares
`timescale 1ns/1ps
module flash_host_ctrl_test;
	localparam logic [7:0] maker = 8'h5A; // arbitrary value
	localparam logic [7:0] part = 8'hC3; // arbitrary value
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fail_set;
	logic ce_n, we_n, oe_n, dq_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [18:0] faddr, a;
	logic [7:0] dq_o, dq_i, dev_q, d;
	logic [65:0] q[$];
	logic [65:0] n;
	int failures, check_count, cyc, seed;
	logic [18:0] ida [4] = '{19'h0_0000, 19'h0_0001, 19'h7_0002, 19'h2_0002};
	logic [7:0] idv [4] = '{maker, part, 8'h01, 8'h00};
	assign dq_i = dq_oe ? dq_o : dev_q;
	flash_host_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
		.flash_addr(faddr), .flash_dq_in(dq_i), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe));
	flash_device_model #(.maker_code(maker), .part_code(part), .guarded(3'h7)) dev (
		.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(faddr), .din(dq_i),
		.fail_set(fail_set), .dq(dev_q));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ----
	// bus tasks
	// ----
	task automatic end_sim();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
		input logic [65:0] note);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		if (!w) q.push_back(note);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic op(input logic [2:0] c, input logic [18:0] fa, input logic [7:0] fd,
		input logic [2:0] st, input logic chk, input logic [7:0] r);
		apb(1'b1, 12'h004, {13'h0000, fa}, '0);
		apb(1'b1, 12'h008, {24'h00_0000, fd}, '0);
		apb(1'b1, 12'h000, {29'h0000_0000, c}, '0);
		rd = '0;
		while (rd[1] !== 1'b1) apb(1'b0, 12'h00C, '0, '0);
		apb(1'b0, 12'h00C, '0, {33'h1_0000_0007, 30'h0000_0000, st});
		if (chk) apb(1'b0, 12'h010, '0, {33'h1_FFFF_FFFF, 25'h000_0000, r});
	endtask
	task automatic rnd();
		logic [31:0] s;
		s = $random(seed);
		a = {(s[18:16] == 3'h7) ? 3'h0 : s[18:16], 8'h11, s[7:0]};
		d = s[31:24];
	endtask
	// ----
	// result monitor and timeout
	// ----
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
		if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
			n = q.pop_front();
			if (n[65:33] != 33'h0_0000_0000) begin
				check_count++;
				if (({pslverr, prdata} & n[65:33]) !== n[32:0]) begin
					failures++;
					$display("CHECK FAILED %0t read %h expected %h", $time, prdata, n[31:0]);
				end
			end
		end
	end
	initial begin
		{psel, penable, pwrite, fail_set, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		{failures, check_count, cyc} = '0;
		seed = 91;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rnd();
			op(3'h1, a, d, 3'h2, 1'b1, d);
			op(3'h4, a, 8'h00, 3'h2, 1'b1, d);
		end
		op(3'h1, 19'h7_1122, d, 3'h2, 1'b1, 8'hFF);
		op(3'h4, 19'h7_1122, 8'h00, 3'h2, 1'b1, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			op(3'h3, ida[i], 8'h00, 3'h2, 1'b1, idv[i]);
		end
		op(3'h0, 19'h0_0000, 8'h00, 3'h2, 1'b0, 8'h00);
		op(3'h4, a, 8'h00, 3'h2, 1'b1, d);
		op(3'h2, a, 8'h00, 3'h2, 1'b1, 8'hFF);
		op(3'h4, a, 8'h00, 3'h2, 1'b1, 8'hFF);
		fail_set <= 1'b1;
		rnd();
		op(3'h1, a, d, 3'h6, 1'b0, 8'h00);
		fail_set <= 1'b0;
		rnd();
		op(3'h1, a, d, 3'h2, 1'b1, d);
		op(3'h5, a, d, 3'h6, 1'b0, 8'h00);
		apb(1'b0, 12'h020, '0, {33'h1_FFFF_FFFF, 33'h1_0000_0000});
		end_sim();
	end
endmodule

// [tb/flash_host_properties.sv]
// Purpose: pin protocol checks on the flash side of the host controller
// Assumes: sees only the top module's ports
// Notes: order checks key on the command word of each write strobe
`timescale 1ns/1ps
module flash_host_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pslverr,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	input wire logic [18:0] flash_addr,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_dq_oe
);
	// ----
	// last write seen on the pins
	// ----
	logic [26:0] prev;
	wire logic [26:0] cur = {flash_addr, flash_dq_out};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= '0;
		end else if (!flash_we_n) begin
			prev <= cur;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_unlock_order: assert property (
		$fell(flash_we_n) && cur == 27'h2A_AA55 |-> prev == 27'h55_55AA)
		else $error("second unlock write without first");
	a_program_order: assert property (
		$fell(flash_we_n) && cur == 27'h55_55A0 |-> prev == 27'h2A_AA55)
		else $error("program command not after unlock");
	a_ident_order: assert property (
		$fell(flash_we_n) && cur == 27'h55_5590 |-> prev == 27'h2A_AA55)
		else $error("identity command not after unlock");
	a_setup_order: assert property (
		$fell(flash_we_n) && cur == 27'h55_5580 |-> prev == 27'h2A_AA55)
		else $error("erase setup not after unlock");
	a_confirm_order: assert property (
		$fell(flash_we_n) && cur == 27'h55_5510 |-> prev == 27'h2A_AA55)
		else $error("erase confirm not after second unlock");
	a_strobe_hold: assert property (
		!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out) && flash_dq_oe
			&& !flash_ce_n && flash_oe_n)
		else $error("address or data moved during write strobe");
	a_read_quiet: assert property (
		!flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
		else $error("host drives data during a read");
	a_data_release: assert property (
		$rose(flash_we_n) |-> ##[0:2] !flash_dq_oe)
		else $error("data not released after write");
	c_confirm: cover property ($fell(flash_we_n) && cur == 27'h55_5510);
	c_program: cover property ($fell(flash_we_n) && cur == 27'h55_55A0);
	c_unmapped: cover property (pslverr);
endmodule

bind flash_host_ctrl flash_host_properties chk (
	.pclk(pclk),
	.presetn(presetn),
	.pslverr(pslverr),
	.flash_ce_n(flash_ce_n),
	.flash_we_n(flash_we_n),
	.flash_oe_n(flash_oe_n),
	.flash_addr(flash_addr),
	.flash_dq_out(flash_dq_out),
	.flash_dq_oe(flash_dq_oe)
);
